// File: hw/sfrc_pkg.sv
// Shared constants, types and helpers of the read configuration block.
// Assumes the block is clocked by core_clk and samples the serial link.
package sfrc_pkg;

  // Command codes of the register and read commands
  localparam logic [7:0] OP_WREN     = 8'h11;
  localparam logic [7:0] OP_WRDI     = 8'h12;
  localparam logic [7:0] OP_RD_FLAG  = 8'h13;
  localparam logic [7:0] OP_CLR_FLAG = 8'h14;
  localparam logic [7:0] OP_RD_NV    = 8'h15;
  localparam logic [7:0] OP_WR_NV    = 8'h16;
  localparam logic [7:0] OP_RD_V     = 8'h17;
  localparam logic [7:0] OP_WR_V     = 8'h18;
  localparam logic [7:0] OP_FAST_RD  = 8'h19;
  localparam logic [7:0] OP_QIO_RD   = 8'h1A;
  localparam logic [7:0] OP_TUNE_RD  = 8'h1B;

  // Persistent register layout
  localparam int NV_ADDR_BIT  = 0;
  localparam int NV_DUAL_BIT  = 2;
  localparam int NV_QUAD_BIT  = 3;
  localparam int NV_DRV_LSB   = 6;
  localparam int NV_XIP_LSB   = 9;
  localparam int NV_DUMMY_LSB = 12;
  localparam logic [2:0]  XIP_NV_OFF  = 3'h7;
  localparam logic [2:0]  XIP_NV_RSV5 = 3'h5;
  localparam logic [2:0]  XIP_NV_RSV6 = 3'h6;
  localparam logic [15:0] NV_RESET    = 16'hFFFF;
  localparam logic [1:0]  NV_BYTES    = 2'h2;

  // Runtime register layout
  localparam int V_DUMMY_LSB = 4;
  localparam int V_XIP_BIT   = 3;
  localparam int V_RSVD_BIT  = 2;
  localparam int V_WRAP_LSB  = 0;
  localparam logic [7:0] V_RESET     = 8'hFB;
  localparam logic [7:0] V_RSVD_MASK = 8'h04;

  localparam logic [1:0] WRAP_16   = 2'h0;
  localparam logic [1:0] WRAP_32   = 2'h1;
  localparam logic [1:0] WRAP_64   = 2'h2;
  localparam logic [1:0] WRAP_CONT = 2'h3;

  localparam int FLAG_PGM_ERR_BIT = 1;
  localparam logic [3:0] DUMMY_DEFAULT = 4'h8;
  localparam logic [3:0] DUMMY_ZERO    = 4'h0;
  localparam logic [3:0] DUMMY_MAX     = 4'hF;
  localparam logic [2:0] ADDR_BYTES_3  = 3'h3;
  localparam logic [2:0] ADDR_BYTES_4  = 3'h4;
  localparam logic [3:0] LANE_Q        = 4'h4;
  localparam logic [3:0] LANE_S        = 4'h1;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] OE_QUAD       = 4'hF;
  localparam logic [3:0] OE_SINGLE     = 4'h2;
  localparam logic [7:0] TUNE_PATTERN  = 8'hA5;

  typedef struct packed {
    logic       addr_4byte;
    logic       quad_mode;
    logic [3:0] dummy_code;
    logic       xip_off;
    logic [1:0] wrap;
  } sfrc_icfg_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } sfrc_fetch_t;

  localparam sfrc_icfg_t ICFG_RESET = {1'b0, 1'b0, 4'hF, 1'b1, 2'h3};

  typedef enum logic [2:0] {
    ST_CMD   = 3'b000,
    ST_ADDR  = 3'b001,
    ST_DUMMY = 3'b010,
    ST_DOUT  = 3'b011,
    ST_DIN   = 3'b100,
    ST_SKIP  = 3'b101
  } sfrc_state_t;

  function automatic logic [3:0] dummy_cycles(input logic [3:0] code);
    if (code == DUMMY_ZERO || code == DUMMY_MAX) return DUMMY_DEFAULT;
    return code;
  endfunction : dummy_cycles

  function automatic sfrc_icfg_t cfg_from_nv(input logic [15:0] nv);
    sfrc_icfg_t c;
    c.addr_4byte = ~nv[NV_ADDR_BIT];
    c.quad_mode  = ~nv[NV_QUAD_BIT] & ~nv[NV_DUAL_BIT];
    c.dummy_code = nv[NV_DUMMY_LSB +: 4];
    c.xip_off    = nv[NV_XIP_LSB +: 3] == XIP_NV_OFF;
    c.wrap       = WRAP_CONT;
    return c;
  endfunction : cfg_from_nv

  function automatic logic [7:0] vcfg_from_nv(input logic [15:0] nv);
    return {nv[NV_DUMMY_LSB +: 4], nv[NV_XIP_LSB +: 3] == XIP_NV_OFF,
            1'b0, WRAP_CONT};
  endfunction : vcfg_from_nv

  function automatic logic nv_reserved(input logic [15:0] nv);
    return nv[NV_XIP_LSB +: 3] == XIP_NV_RSV5 ||
           nv[NV_XIP_LSB +: 3] == XIP_NV_RSV6 || !nv[NV_DRV_LSB];
  endfunction : nv_reserved

  function automatic logic [31:0] wrap_next(input logic [31:0] a,
                                            input logic [1:0]  w);
    logic [31:0] r;
    case (w)
      WRAP_16: r = {a[31:4], 4'(a[3:0] + 4'h1)};
      WRAP_32: r = {a[31:5], 5'(a[4:0] + 5'h01)};
      WRAP_64: r = {a[31:6], 6'(a[5:0] + 6'h01)};
      default: r = a + 32'h1;
    endcase
    return r;
  endfunction : wrap_next

endpackage : sfrc_pkg

// File: hw/sfrc_buf2.sv
// Small FIFO in the read data path between memory and serial output.
// Assumes DEPTH is a power of two; flush empties it in one cycle.
`timescale 1ns/1ps
`default_nettype none
module sfrc_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_reg != FULL;
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem_reg[rptr_reg];
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else if (flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      if (push) wptr_reg <= AW'(wptr_reg + 1'b1);
      if (pop) rptr_reg <= AW'(rptr_reg + 1'b1);
      if (push && !pop) cnt_reg <= (AW + 1)'(cnt_reg + 1'b1);
      else if (pop && !push) cnt_reg <= (AW + 1)'(cnt_reg - 1'b1);
    end
  end
endmodule : sfrc_buf2
`default_nettype wire

// File: hw/sfrc_core.sv
// Read configuration logic of a serial NOR flash, behind its pins.
// Assumes link pins are asynchronous to core_clk and far slower than it.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Address width is four bytes when persistent bit 0 is 0, else three.
// - Persistent contents load into the operating config on every reset.
// - Both persistent dual and quad bits at 0 select the four-lane mode.
// - Runtime register is read and written by commands; writes act at once.
// - Dummy field codes 1-14 give that count; 0 and 15 give the default 8.
// - Fast reads insert the configured dummy cycles before data leaves.
// - Runtime bit 3 at 0 enables execute-in-place; 1, the default, not.
// - Runtime bits 1:0 pick 16, 32, 64 byte wrap or continuous (default).
// - Wrap reads start at the address and cycle in the aligned block.
// - Continuous reads keep incrementing over the whole array.
// - A tuning pattern read lets the host adjust its capture point.
// - Reserved persistent writes are dropped, flag bit 1 set, latch clear.
module sfrc_core
  import sfrc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        link_sclk,
  input  wire logic        link_cs_b,
  input  wire logic [3:0]  link_dq_in,
  output logic      [3:0]  link_dq_out,
  output logic      [3:0]  link_dq_oe,
  input  wire logic        dev_reset_b,
  output sfrc_fetch_t      fetch,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_rvalid,
  output sfrc_icfg_t       icfg
);
  logic        sclk_s1, sclk_s2, sclk_s3;
  logic        cs_s1, cs_s2, cs_s3;
  logic        rst_s1, rst_s2;
  logic [3:0]  dq_s1, dq_s2;
  sfrc_state_t state_reg;
  logic [7:0]  sh_reg, op_reg, oshift_reg, flag_reg, vcfg_reg;
  logic [3:0]  bcnt_reg, dcnt_reg, ocnt_reg, dq_out_reg, dq_oe_reg;
  logic [2:0]  abyte_reg;
  logic [1:0]  nbyte_reg;
  logic [31:0] addr_reg, rdaddr_reg, last_addr_reg;
  logic [15:0] wbuf_reg, nv_reg;
  logic        wide_reg, xconf_reg, alt_reg, wel_reg, xip_act_reg;
  logic        outst_reg, stale_reg, seq_reg;
  sfrc_icfg_t  icfg_reg;
  sfrc_fetch_t fetch_reg;
  logic        rise, fall, active, cs_end, lanes4, byte_done, is_mem;
  logic        rst_run, fetch_ok, push, pop, buf_ready, buf_valid;
  logic [3:0]  step, bcnt_sum, dcyc, dcnt_inc;
  logic [2:0]  nabytes, abyte_inc;
  logic [7:0]  sh_next, nb, obyte, buf_data;
  logic [31:0] addr_nx, rd_start;

  assign link_dq_out = dq_out_reg;
  assign link_dq_oe  = dq_oe_reg;
  assign fetch       = fetch_reg;
  assign icfg        = icfg_reg;

  // Pin synchronisers; edges are judged on the second and third stages
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      cs_s3   <= 1'b1;
      rst_s1  <= 1'b1;
      rst_s2  <= 1'b1;
      dq_s1   <= 4'h0;
      dq_s2   <= 4'h0;
    end else begin
      sclk_s1 <= link_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1   <= link_cs_b;
      cs_s2   <= cs_s1;
      cs_s3   <= cs_s2;
      rst_s1  <= dev_reset_b;
      rst_s2  <= rst_s1;
      dq_s1   <= link_dq_in;
      dq_s2   <= dq_s1;
    end
  end

  assign rise      = sclk_s2 & ~sclk_s3;
  assign fall      = ~sclk_s2 & sclk_s3;
  assign active    = ~cs_s2;
  assign cs_end    = cs_s2 & ~cs_s3;
  assign rst_run   = rst_s2;
  assign lanes4    = icfg_reg.quad_mode |
                     ((state_reg != ST_CMD) & wide_reg);
  assign step      = lanes4 ? LANE_Q : LANE_S;
  assign sh_next   = lanes4 ? {sh_reg[3:0], dq_s2} : {sh_reg[6:0], dq_s2[0]};
  assign bcnt_sum  = bcnt_reg + step;
  assign byte_done = bcnt_sum == BYTE_BITS;
  assign nabytes   = icfg_reg.addr_4byte ? ADDR_BYTES_4 : ADDR_BYTES_3;
  assign abyte_inc = abyte_reg + 3'h1;
  assign dcyc      = dummy_cycles(icfg_reg.dummy_code);
  assign dcnt_inc  = dcnt_reg + 4'h1;
  assign is_mem    = (op_reg == OP_FAST_RD) | (op_reg == OP_QIO_RD);
  assign addr_nx   = {addr_reg[23:0], sh_next};
  assign rd_start  = icfg_reg.addr_4byte ? addr_nx : {8'h00, addr_nx[23:0]};

  function automatic sfrc_state_t cmd_state(input logic [7:0] op);
    case (op)
      OP_RD_FLAG, OP_RD_NV, OP_RD_V, OP_TUNE_RD: return ST_DOUT;
      OP_WR_NV, OP_WR_V:                         return ST_DIN;
      OP_FAST_RD, OP_QIO_RD:                     return ST_ADDR;
      default:                                   return ST_SKIP;
    endcase
  endfunction : cmd_state

  // Serial frame decode on rising link edges
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_CMD;
      sh_reg    <= 8'h00;
      bcnt_reg  <= 4'h0;
      op_reg    <= 8'h00;
      abyte_reg <= 3'h0;
      addr_reg  <= 32'h0;
      dcnt_reg  <= 4'h0;
      wide_reg  <= 1'b0;
      nbyte_reg <= 2'h0;
      wbuf_reg  <= 16'h0;
      xconf_reg <= 1'b0;
    end else if (!rst_run || !active) begin
      // In execute-in-place a frame opens straight at the address
      state_reg <= (xip_act_reg && rst_run) ? ST_ADDR : ST_CMD;
      bcnt_reg  <= 4'h0;
      abyte_reg <= 3'h0;
      addr_reg  <= 32'h0;
      dcnt_reg  <= 4'h0;
      nbyte_reg <= 2'h0;
    end else if (rise) begin
      sh_reg   <= sh_next;
      bcnt_reg <= byte_done ? 4'h0 : bcnt_sum;
      unique case (state_reg)
        ST_CMD: begin
          if (byte_done) begin
            op_reg    <= sh_next;
            wide_reg  <= sh_next == OP_QIO_RD;
            state_reg <= cmd_state(sh_next);
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            addr_reg  <= addr_nx;
            abyte_reg <= abyte_inc;
            if (abyte_inc == nabytes) state_reg <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (dcnt_reg == 4'h0) xconf_reg <= dq_s2[0];
          dcnt_reg <= dcnt_inc;
          if (dcnt_inc == dcyc) state_reg <= ST_DOUT;
        end
        ST_DIN: begin
          if (byte_done && nbyte_reg != NV_BYTES) begin
            if (nbyte_reg == 2'h0) wbuf_reg[7:0] <= sh_next;
            else wbuf_reg[15:8] <= sh_next;
            nbyte_reg <= nbyte_reg + 2'h1;
          end
        end
        ST_DOUT, ST_SKIP: begin
        end
        default: state_reg <= ST_SKIP;
      endcase
    end
  end

  // Byte offered to the output shifter at each byte boundary
  always_comb begin
    nb = 8'h00;
    case (op_reg)
      OP_RD_FLAG: nb = flag_reg;
      OP_RD_V:    nb = vcfg_reg;
      OP_RD_NV:   nb = alt_reg ? nv_reg[15:8] : nv_reg[7:0];
      OP_TUNE_RD: nb = alt_reg ? ~TUNE_PATTERN : TUNE_PATTERN;
      default: begin
        // Too few dummy cycles leaves the buffer empty: zeros go out
        if (is_mem && buf_valid) nb = buf_data;
      end
    endcase
  end

  assign obyte = (ocnt_reg == 4'h0) ? nb : oshift_reg;
  assign pop   = fall & active & (state_reg == ST_DOUT) &
                 (ocnt_reg == 4'h0) & is_mem;

  // Output lanes change on falling link edges and are cleared when the frame closes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oshift_reg <= 8'h00;
      ocnt_reg   <= 4'h0;
      alt_reg    <= 1'b0;
      dq_out_reg <= 4'h0;
      dq_oe_reg  <= 4'h0;
    end else if (!active) begin
      ocnt_reg   <= 4'h0;
      alt_reg    <= 1'b0;
      dq_out_reg <= 4'h0;
      dq_oe_reg  <= 4'h0;
    end else if (fall && state_reg == ST_DOUT) begin
      oshift_reg <= lanes4 ? {obyte[3:0], 4'h0} : {obyte[6:0], 1'b0};
      ocnt_reg   <= (ocnt_reg == 4'h0) ? BYTE_BITS - step : ocnt_reg - step;
      if (ocnt_reg == 4'h0) alt_reg <= ~alt_reg;
      dq_out_reg <= lanes4 ? obyte[7:4] : {2'b00, obyte[7], 1'b0};
      dq_oe_reg  <= lanes4 ? OE_QUAD : OE_SINGLE;
    end
  end

  // Configuration state; commands take effect when the frame closes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      icfg_reg    <= ICFG_RESET;
      nv_reg      <= NV_RESET;
      vcfg_reg    <= V_RESET;
      flag_reg    <= 8'h00;
      wel_reg     <= 1'b0;
      xip_act_reg <= 1'b0;
    end else if (!rst_run) begin
      icfg_reg    <= cfg_from_nv(nv_reg);
      vcfg_reg    <= vcfg_from_nv(nv_reg);
      flag_reg    <= 8'h00;
      wel_reg     <= 1'b0;
      xip_act_reg <= nv_reg[NV_XIP_LSB +: 3] != XIP_NV_OFF;
    end else if (cs_end) begin
      case (op_reg)
        OP_WREN: if (state_reg == ST_SKIP) wel_reg <= 1'b1;
        OP_WRDI: if (state_reg == ST_SKIP) wel_reg <= 1'b0;
        OP_CLR_FLAG: begin
          if (state_reg == ST_SKIP) flag_reg[FLAG_PGM_ERR_BIT] <= 1'b0;
        end
        OP_WR_V: begin
          if (state_reg == ST_DIN && wel_reg && nbyte_reg != 2'h0 &&
              bcnt_reg == 4'h0) begin
            vcfg_reg            <= wbuf_reg[7:0] & ~V_RSVD_MASK;
            icfg_reg.dummy_code <= wbuf_reg[V_DUMMY_LSB +: 4];
            icfg_reg.xip_off    <= wbuf_reg[V_XIP_BIT];
            icfg_reg.wrap       <= wbuf_reg[V_WRAP_LSB +: 2];
            wel_reg             <= 1'b0;
          end
        end
        OP_WR_NV: begin
          if (state_reg == ST_DIN && wel_reg && nbyte_reg == NV_BYTES &&
              bcnt_reg == 4'h0) begin
            if (nv_reserved(wbuf_reg)) flag_reg[FLAG_PGM_ERR_BIT] <= 1'b1;
            else nv_reg <= wbuf_reg;
            wel_reg <= 1'b0;
          end
        end
        OP_FAST_RD, OP_QIO_RD: begin
          // First dummy bit high is the host's request to leave
          if (state_reg == ST_DOUT) begin
            xip_act_reg <= ~icfg_reg.xip_off & ~xconf_reg;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Memory fetch: one request in flight, gated by buffer room
  assign fetch_ok = active & rst_run & is_mem & ~outst_reg & buf_ready &
                    ((state_reg == ST_DUMMY) | (state_reg == ST_DOUT));
  assign push     = mem_rvalid & ~stale_reg & active & is_mem;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_reg  <= '0;
      rdaddr_reg <= 32'h0;
      outst_reg  <= 1'b0;
      stale_reg  <= 1'b0;
    end else begin
      fetch_reg.req <= 1'b0;
      if (mem_rvalid) outst_reg <= 1'b0;
      // A reply still owed when the frame closes must not leak onward
      stale_reg <= (stale_reg | (cs_end & outst_reg)) & ~mem_rvalid;
      if (rise && active && state_reg == ST_ADDR && byte_done &&
          abyte_inc == nabytes) begin
        rdaddr_reg <= rd_start;
      end else if (fetch_ok) begin
        fetch_reg  <= '{req: 1'b1, addr: rdaddr_reg};
        rdaddr_reg <= wrap_next(rdaddr_reg, icfg_reg.wrap);
        outst_reg  <= 1'b1;
      end
    end
  end

  sfrc_buf2 #(
    .WIDTH (8),
    .DEPTH (2)
  ) u_buf (
    .clk       (core_clk),
    .rst_b     (rst_b),
    .flush     (~active),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .in_data   (mem_rdata),
    .out_valid (buf_valid),
    .out_ready (pop),
    .out_data  (buf_data)
  );

  // Helper history of fetch addresses within one frame
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_addr_reg <= 32'h0;
      seq_reg       <= 1'b0;
    end else if (!active) begin
      seq_reg <= 1'b0;
    end else if (fetch_reg.req) begin
      last_addr_reg <= fetch_reg.addr;
      seq_reg       <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  AST_ADDR_BYTES: assert property (
    state_reg == ST_DUMMY && $past(state_reg) == ST_ADDR |->
      abyte_reg == (icfg_reg.addr_4byte ? ADDR_BYTES_4 : ADDR_BYTES_3))
    else $error("address byte count does not match width setting");

  AST_NV_RELOAD: assert property (
    !rst_s2 |=> icfg_reg == cfg_from_nv($past(nv_reg)))
    else $error("operating config not reloaded from persistent copy");

  AST_QUAD_MODE: assert property (
    !rst_s2 ##1 rst_s2 |->
      icfg_reg.quad_mode == (!nv_reg[NV_QUAD_BIT] && !nv_reg[NV_DUAL_BIT]))
    else $error("four-lane mode does not follow persistent bits");

  AST_VWR_APPLY: assert property (
    cs_end && rst_s2 && op_reg == OP_WR_V && state_reg == ST_DIN &&
    wel_reg && nbyte_reg != 2'h0 && bcnt_reg == 4'h0 |=>
      icfg_reg.dummy_code == vcfg_reg[V_DUMMY_LSB +: 4] &&
      icfg_reg.wrap == vcfg_reg[V_WRAP_LSB +: 2] &&
      !vcfg_reg[V_RSVD_BIT] && !wel_reg)
    else $error("runtime write did not reach operating config");

  AST_DUMMY_LEN: assert property (
    state_reg == ST_DOUT && $past(state_reg) == ST_DUMMY |->
      dcnt_reg == dummy_cycles(icfg_reg.dummy_code))
    else $error("dummy phase length wrong");

  AST_NO_DRIVE: assert property (
    state_reg == ST_ADDR || state_reg == ST_DUMMY |-> dq_oe_reg == 4'h0)
    else $error("data lanes driven before dummy phase ended");

  AST_XIP_OFF: assert property (
    cs_end && rst_s2 && is_mem && state_reg == ST_DOUT &&
    icfg_reg.xip_off |=> !xip_act_reg)
    else $error("execute-in-place entered while disabled");

  AST_WRAP_SEQ: assert property (
    fetch_reg.req && seq_reg |->
      fetch_reg.addr == wrap_next(last_addr_reg, icfg_reg.wrap))
    else $error("read address sequence breaks wrap setting");

  AST_NV_RSVD: assert property (
    cs_end && rst_s2 && op_reg == OP_WR_NV && state_reg == ST_DIN &&
    wel_reg && nbyte_reg == NV_BYTES && bcnt_reg == 4'h0 &&
    nv_reserved(wbuf_reg) |=>
      flag_reg[FLAG_PGM_ERR_BIT] && !wel_reg && $stable(nv_reg))
    else $error("reserved persistent write not refused");

  AST_V_RESET: assert property (
    !rst_s2 |=> vcfg_reg == vcfg_from_nv($past(nv_reg)))
    else $error("runtime register inconsistent after reset");

  COV_FAST_READ: cover property (
    state_reg == ST_DOUT && is_mem && fall);
  COV_NV_ERROR: cover property ($rose(flag_reg[FLAG_PGM_ERR_BIT]));
  COV_WRAP16: cover property (
    fetch_reg.req && seq_reg && icfg_reg.wrap == WRAP_16 &&
    fetch_reg.addr[3:0] == 4'h0);
  COV_XIP: cover property ($rose(xip_act_reg));
endmodule : sfrc_core
`default_nettype wire

// File: sim/sfrc_host.sv
// Host model: drives single-lane serial frames and samples lane 1.
// Assumes core_clk at 25 MHz; one link period is eight core cycles.
`timescale 1ns/1ps
`default_nettype none
module sfrc_host (
  input  wire logic       core_clk,
  output logic            link_sclk,
  output logic            link_cs_b,
  output logic      [3:0] link_dq_in,
  input  wire logic [3:0] link_dq_out,
  input  wire logic [3:0] link_dq_oe
);
  initial begin
    link_sclk  = 1'b0;
    link_cs_b  = 1'b1;
    link_dq_in = 4'hA;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // Clock stands low between frames; released lanes keep toggling
  // A 320 ns link period meets every dummy count's clock limit
  task automatic xfer(input logic [63:0] tx, input int nt, input int nr,
                      output logic [63:0] rx);
    rx = '0;
    link_cs_b <= 1'b0;
    tick(4);
    for (int i = 0; i < nt + nr; i++) begin
      link_dq_in <= (i < nt) ? {3'h5, tx[nt-1-i]} : ~link_dq_in;
      tick(4);
      link_sclk <= 1'b1;
      tick(4);
      // Sampled late: output only settles some cycles after the fall
      // A released lane reads back inverted, so a lost enable shows up
      if (i >= nt) rx = {rx[62:0], link_dq_oe[1] ? link_dq_out[1]
                                                 : ~link_dq_out[1]};
      link_sclk <= 1'b0;
    end
    tick(4);
    link_cs_b  <= 1'b1;
    link_dq_in <= ~link_dq_in;
    tick(16);
  endtask : xfer
endmodule : sfrc_host
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench: host model on the link, memory responder here.
// Assumes the design answers register reads from the first data edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfrc_pkg::*;
  logic        core_clk    = 1'b0;
  logic        rst_b       = 1'b0;
  logic        dev_reset_b = 1'b1;
  logic        link_sclk, link_cs_b;
  logic [3:0]  link_dq_in, link_dq_out, link_dq_oe, d;
  sfrc_fetch_t fetch;
  sfrc_icfg_t  icfg, ec;
  logic [7:0]  mem_rdata  = 8'h00;
  logic        mem_rvalid = 1'b0;
  logic [31:0] pa         = '0;
  logic [1:0]  dly        = '0;
  logic [63:0] rx;
  logic [7:0]  v;
  logic [31:0] ra;
  int          n_fail = 0, total_checks = 0, cyc = 0, n;
  always #20 core_clk = ~core_clk;
  sfrc_core sfrc_core_i (.core_clk(core_clk), .rst_b(rst_b),
    .link_sclk(link_sclk), .link_cs_b(link_cs_b), .link_dq_in(link_dq_in),
    .link_dq_out(link_dq_out), .link_dq_oe(link_dq_oe),
    .dev_reset_b(dev_reset_b), .fetch(fetch), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .icfg(icfg));
  sfrc_host sfrc_host_i (.core_clk(core_clk), .link_sclk(link_sclk),
    .link_cs_b(link_cs_b), .link_dq_in(link_dq_in),
    .link_dq_out(link_dq_out), .link_dq_oe(link_dq_oe));
  // Memory answers after a random delay; idle data never holds still
  always @(posedge core_clk) begin
    mem_rvalid <= 1'b0;
    mem_rdata  <= ~mem_rdata;
    if (fetch.req) begin
      pa  <= fetch.addr;
      dly <= 2'($urandom_range(1, 3));
    end else if (dly != 2'h0) begin
      dly <= dly - 2'h1;
      if (dly == 2'h1) begin
        mem_rvalid <= 1'b1;
        mem_rdata  <= mb(pa);
      end
    end
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      print_verdict();
    end
  end
  function automatic logic [7:0] mb(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : mb
  function automatic logic [31:0] msk(input logic [1:0] w);
    return (32'h10 << w) - 32'h1;
  endfunction : msk
  function automatic logic [31:0] nxt(input logic [31:0] a,
                                      input logic [1:0]  w);
    logic [31:0] m;
    m = (w == 2'h3) ? 32'hFFFFFFFF : msk(w);
    return (a & ~m) | ((a + 32'h1) & m);
  endfunction : nxt
  task automatic chk_b(input string s, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk_b
  task automatic chk_c(input sfrc_icfg_t e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED icfg exp %h got %h", e, g);
    end
  endtask : chk_c
  task automatic cmd(input logic [63:0] tx, input int nt, input int nr);
    sfrc_host_i.xfer(tx, nt, nr, rx);
  endtask : cmd
  task automatic frd(input logic [31:0] a, input logic [1:0] w,
                     input int dn, input int nb, input bit x);
    logic [31:0] e;
    logic [63:0] t;
    e = a;
    t = (nb == 4) ? {24'h0, OP_FAST_RD, a} : {32'h0, OP_FAST_RD, a[23:0]};
    // Execute-in-place frame: no command, first dummy bit asks to leave
    if (x) t = {32'h0, a};
    t = t << dn;
    if (x) t[dn-1] = 1'b1;
    cmd(t, 8 * nb + dn + (x ? 0 : 8), 64);
    for (int k = 0; k < 8; k++) begin
      chk_b("rdata", 16'(mb(e)), 16'(rx[63-8*k -: 8]));
      e = nxt(e, w);
    end
  endtask : frd
  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    void'($urandom(32'hEFC1C184));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk_c({2'b00, 4'hF, 1'b1, 2'h3}, icfg);
    cmd({56'h0, OP_RD_V}, 8, 8);
    chk_b("runtime", 16'h00FB, rx[15:0]);
    for (int w = 0; w < 4; w++) begin
      d = (w < 2) ? 4'(w) : 4'($urandom_range(2, 14));
      v = {d, 1'b1, 1'b0, 2'(w)};
      cmd({56'h0, OP_WREN}, 8, 0);
      cmd({48'h0, OP_WR_V, v}, 16, 0);
      ec = {2'b00, d, 1'b1, 2'(w)};
      chk_c(ec, icfg);
      cmd({56'h0, OP_RD_V}, 8, 8);
      chk_b("runtime", {8'h0, v}, rx[15:0]);
      n = (d == 4'h0) ? 8 : int'(d);
      ra = {8'h00, 24'($urandom)};
      frd((ra & ~msk(2'(w))) | (msk(2'(w)) - 32'h2), 2'(w), n, 3, 1'b0);
    end
    cmd({56'h0, OP_TUNE_RD}, 8, 16);
    chk_b("tune", 16'hA55A, rx[15:0]);
    cmd({56'h0, OP_WREN}, 8, 0);
    cmd({40'h0, OP_WR_NV, 16'hFFFB}, 24, 0);
    cmd({56'h0, OP_RD_FLAG}, 8, 8);
    chk_b("flag", 16'h0002, {8'h0, rx[7:0] & 8'h02});
    cmd({56'h0, OP_RD_NV}, 8, 16);
    chk_b("persist", 16'hFFFF, rx[15:0]);
    cmd({56'h0, OP_CLR_FLAG}, 8, 0);
    cmd({56'h0, OP_RD_FLAG}, 8, 8);
    chk_b("flag", 16'h0000, {8'h0, rx[7:0] & 8'h02});
    cmd({48'h0, OP_WR_V, 8'h00}, 16, 0);
    chk_c(ec, icfg);
    cmd({56'h0, OP_WREN}, 8, 0);
    cmd({56'h0, OP_WRDI}, 8, 0);
    cmd({48'h0, OP_WR_V, 8'h00}, 16, 0);
    chk_c(ec, icfg);
    cmd({56'h0, OP_WREN}, 8, 0);
    cmd({40'h0, OP_WR_NV, 16'hFA5F}, 24, 0);
    cmd({56'h0, OP_RD_NV}, 8, 16);
    chk_b("persist", 16'hFA5F, rx[15:0]);
    dev_reset_b <= 1'b0;
    repeat (8) @(posedge core_clk);
    dev_reset_b <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk_c({2'b10, 4'h5, 1'b1, 2'h3}, icfg);
    cmd({56'h0, OP_RD_V}, 8, 8);
    chk_b("runtime", 16'h005B, rx[15:0]);
    frd($urandom | 32'hFF, 2'h3, 5, 4, 1'b0);
    cmd({56'h0, OP_WREN}, 8, 0);
    cmd({48'h0, OP_WR_V, 8'h53}, 16, 0);
    chk_c({2'b10, 4'h5, 1'b0, 2'h3}, icfg);
    frd($urandom, 2'h3, 5, 4, 1'b0);
    frd($urandom, 2'h3, 5, 4, 1'b1);
    cmd({56'h0, OP_RD_V}, 8, 8);
    chk_b("runtime", 16'h0053, rx[15:0]);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
